// [icam_top.sv]
// Purpose: Master Stop/Repeated Start/receive sequencer and slave address masking
// Assumes: AHB-Lite slave on mclk_i, SCL and SDA open-drain, sampled via two flops
// Notes: Stop/restart/receive bits self-clear only in master mode
`timescale 1ns/10ps
module icam_top
  import icam_pkg::*;
#(
  parameter int QTR_CYC = SCL_QTR_CYC
)
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [6:0] own_r, own_nxt;
  logic match_r, match_nxt;
  logic rxv_r, rxv_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic [7:0] baddr_r, baddr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic hready_r, hready_nxt;
  logic scl_m_r, scl_s_r, scl_p_r, sda_m_r, sda_s_r, sda_p_r;
  icam_state_t st_r, st_nxt;
  logic [15:0] div_r, div_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] msh_r, msh_nxt;
  logic scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
  logic clr_rs, clr_stop, clr_rx, rx_done, tick, master_on, slave_on;
  logic sl_act_r, sl_act_nxt;
  logic [3:0] sl_cnt_r, sl_cnt_nxt;
  logic [7:0] ssh_r, ssh_nxt;
  logic cmp, hit, acc;
  logic [6:0] mask7;

  // Bit 0 has no mask enable; only bits 3..1 can be ignored
  function automatic logic addr_hit(input logic [6:0] rx, input logic [6:0] own,
                                    input logic [6:0] msk);
    addr_hit = ((rx ^ own) & ~msk) == 7'h00;
  endfunction

  assign master_on = ctrl_r[ENABLE_BIT] && ctrl_r[MODE_BIT];
  assign slave_on = ctrl_r[ENABLE_BIT] && !ctrl_r[MODE_BIT];
  // RQ2 RQ4 RQ6 mask enables
  assign mask7 = {3'h0, ctrl_r[RECV_BIT], ctrl_r[STOP_BIT], ctrl_r[RESTART_BIT], 1'b0};
  assign acc = hsel_i && htrans_i[1] && hready_i;
  assign cmp = sl_act_r && (sl_cnt_r == ADDR_FRAME_BITS);
  // RQ7 masked compare
  assign hit = addr_hit(ssh_r[7:1], own_r, mask7);
  assign tick = div_r == 16'(QTR_CYC - 1);

  // Bus and register file; reads take one wait state so a write just before is seen
  always_comb
  begin
    wr_pend_nxt = acc && hwrite_i;
    rd_pend_nxt = acc && !hwrite_i;
    hready_nxt = !rd_pend_nxt;
    baddr_nxt = baddr_r;
    if (acc)
    begin
      baddr_nxt = (haddr_i[31:8] == 24'h0) ? haddr_i[7:0] : NO_REG;
    end
    hrdata_nxt = hrdata_r;
    if (rd_pend_r)
    begin
      if (baddr_r == CTRL_OFS)
        hrdata_nxt = {24'h0, ctrl_r};
      else if (baddr_r == OWN_ADDR_OFS)
        hrdata_nxt = {25'h0, own_r};
      else if (baddr_r == STATUS_OFS)
        hrdata_nxt = {16'h0, rxd_r, 4'h0, sda_s_r, st_r != ICAM_IDLE, rxv_r, match_r};
      else
        hrdata_nxt = 32'h0;
    end
    ctrl_nxt = ctrl_r;
    // RQ3 stop self-clear
    if (clr_stop)
      ctrl_nxt[STOP_BIT] = 1'b0;
    // RQ5 restart self-clear
    if (clr_rs)
      ctrl_nxt[RESTART_BIT] = 1'b0;
    if (clr_rx)
      ctrl_nxt[RECV_BIT] = 1'b0;
    // Software write wins so a fresh request is never dropped
    if (wr_pend_r && baddr_r == CTRL_OFS)
      ctrl_nxt = hwdata_i[7:0];
    own_nxt = own_r;
    if (wr_pend_r && baddr_r == OWN_ADDR_OFS)
      own_nxt = hwdata_i[6:0];
    match_nxt = match_r;
    rxv_nxt = rxv_r;
    if (wr_pend_r && baddr_r == STATUS_OFS)
    begin
      match_nxt = match_r && !hwdata_i[ST_MATCH_BIT];
      rxv_nxt = rxv_r && !hwdata_i[ST_RXV_BIT];
    end
    // Hardware set beats a same-cycle clear
    if (cmp && hit)
      match_nxt = 1'b1;
    if (rx_done)
      rxv_nxt = 1'b1;
    rxd_nxt = rx_done ? {msh_r[6:0], sda_s_r} : rxd_r;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hready_r <= 1'b1;
      baddr_r <= NO_REG;
      hrdata_r <= 32'h0;
      ctrl_r <= CTRL_RST;
      own_r <= OWN_ADDR_RST;
      match_r <= 1'b0;
      rxv_r <= 1'b0;
      rxd_r <= RXD_RST;
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_p_r <= 1'b1;
    end
    else if (ce_i)
    begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      hready_r <= hready_nxt;
      baddr_r <= baddr_nxt;
      hrdata_r <= hrdata_nxt;
      ctrl_r <= ctrl_nxt;
      own_r <= own_nxt;
      match_r <= match_nxt;
      rxv_r <= rxv_nxt;
      rxd_r <= rxd_nxt;
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_p_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_p_r <= sda_s_r;
    end
  end

  // Master sequencer; each state but ICAM_IDLE lasts one quarter SCL period, no clock stretching
  always_comb
  begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    msh_nxt = msh_r;
    clr_rs = 1'b0;
    clr_stop = 1'b0;
    clr_rx = 1'b0;
    rx_done = 1'b0;
    div_nxt = (st_r == ICAM_IDLE || tick) ? 16'h0 : div_r + 16'h1;
    case (st_r)
      ICAM_IDLE:
      begin
        bit_nxt = 4'h0;
        // Restart outranks Stop, which outranks receive
        if (master_on && ctrl_r[RESTART_BIT])
          st_nxt = ICAM_RS_SDA;
        else if (master_on && ctrl_r[STOP_BIT])
          st_nxt = ICAM_P_SDA;
        // RQ1 receive launch
        else if (master_on && ctrl_r[RECV_BIT])
          st_nxt = ICAM_RX_LOW;
      end
      ICAM_RS_SDA: if (tick) st_nxt = ICAM_RS_SCL;
      ICAM_RS_SCL: if (tick) st_nxt = ICAM_RS_START;
      ICAM_RS_START: if (tick) st_nxt = ICAM_RS_HOLD;
      ICAM_RS_HOLD:
      begin
        if (tick)
        begin
          st_nxt = ICAM_IDLE;
          clr_rs = 1'b1;
        end
      end
      ICAM_P_SDA: if (tick) st_nxt = ICAM_P_SCL;
      ICAM_P_SCL: if (tick) st_nxt = ICAM_P_REL;
      ICAM_P_REL:
      begin
        if (tick)
        begin
          st_nxt = ICAM_IDLE;
          clr_stop = 1'b1;
        end
      end
      ICAM_RX_LOW: if (tick) st_nxt = ICAM_RX_HIGH;
      ICAM_RX_HIGH:
      begin
        if (tick)
        begin
          msh_nxt = {msh_r[6:0], sda_s_r};
          bit_nxt = bit_r + 4'h1;
          st_nxt = ICAM_RX_LOW;
          if (bit_r == RX_BITS - 4'h1)
          begin
            st_nxt = ICAM_IDLE;
            rx_done = 1'b1;
            clr_rx = 1'b1;
          end
        end
      end
      default: st_nxt = ICAM_IDLE;
    endcase
    // Leaving master mode aborts; a late self-clear must not eat slave mask enables
    if (!master_on)
    begin
      st_nxt = ICAM_IDLE;
      clr_rs = 1'b0;
      clr_stop = 1'b0;
      clr_rx = 1'b0;
      rx_done = 1'b0;
    end
    scl_oe_nxt = st_nxt inside {ICAM_RS_SDA, ICAM_RS_HOLD, ICAM_P_SDA, ICAM_RX_LOW};
    sda_oe_nxt = st_nxt inside {ICAM_RS_START, ICAM_RS_HOLD, ICAM_P_SDA, ICAM_P_SCL};
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_r <= ICAM_IDLE;
      div_r <= 16'h0;
      bit_r <= 4'h0;
      msh_r <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      msh_r <= msh_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // Slave address capture; one compare per Start, no acknowledge is driven
  always_comb
  begin
    sl_act_nxt = sl_act_r;
    sl_cnt_nxt = sl_cnt_r;
    ssh_nxt = ssh_r;
    if (!slave_on || (scl_s_r && !sda_p_r && sda_s_r))
      sl_act_nxt = 1'b0;
    else if (scl_s_r && sda_p_r && !sda_s_r)
    begin
      sl_act_nxt = 1'b1;
      sl_cnt_nxt = 4'h0;
    end
    else if (cmp)
      sl_act_nxt = 1'b0;
    else if (sl_act_r && !scl_p_r && scl_s_r)
    begin
      ssh_nxt = {ssh_r[6:0], sda_s_r};
      sl_cnt_nxt = sl_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sl_act_r <= 1'b0;
      sl_cnt_r <= 4'h0;
      ssh_r <= 8'h00;
    end
    else if (ce_i)
    begin
      sl_act_r <= sl_act_nxt;
      sl_cnt_r <= sl_cnt_nxt;
      ssh_r <= ssh_nxt;
    end
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = hready_r;
  assign hresp_o = 1'b0 & hready_r;
  assign scl_o = 1'b0 & scl_oe_r;
  assign sda_o = 1'b0 & sda_oe_r;
  assign scl_oe_o = scl_oe_r;
  assign sda_oe_o = sda_oe_r;

  localparam int A_SEQ_MAX = 4 * QTR_CYC + 2;
  default clocking a_clk @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i || !ce_i);

  sequence s_rs_launch;
    st_r == ICAM_IDLE && master_on && ctrl_r[RESTART_BIT];
  endsequence
  sequence s_rs_edge;
    st_r == ICAM_RS_START && !scl_oe_r && sda_oe_r;
  endsequence
  sequence s_stop_launch;
    st_r == ICAM_IDLE && master_on && !ctrl_r[RESTART_BIT] && ctrl_r[STOP_BIT];
  endsequence

  a_rx_launch: assert property (st_r == ICAM_IDLE && master_on && ctrl_r[RECV_BIT] && // RQ1
    !ctrl_r[STOP_BIT] && !ctrl_r[RESTART_BIT] |=> st_r == ICAM_RX_LOW ##1 scl_oe_r)
    else $error("receive request did not start reception");
  a_rx_idle: assert property (st_r == ICAM_IDLE && !(master_on && ctrl_r[3:1] != 3'h0) // RQ1
    |=> st_r == ICAM_IDLE && !scl_oe_r)
    else $error("master left idle without a request");
  a_stop_done: assert property (s_stop_launch |=> ##[1:A_SEQ_MAX] // RQ3
    (!ctrl_r[STOP_BIT] && !scl_oe_r && !sda_oe_r && $past(sda_oe_r, 1 + QTR_CYC)))
    else $error("stop condition not completed and cleared");
  a_restart_seq: assert property (s_rs_launch |=> ##[1:A_SEQ_MAX] s_rs_edge // RQ5
    ##[1:A_SEQ_MAX] !ctrl_r[RESTART_BIT])
    else $error("repeated start not generated or not cleared");
  a_mask_bit3: assert property (cmp && ctrl_r[RECV_BIT] && (ssh_r[7:1] ^ own_r) == 7'h08 // RQ2
    |=> match_r)
    else $error("masked address bit 3 blocked a match");
  a_mask_bit2: assert property (cmp && ctrl_r[STOP_BIT] && (ssh_r[7:1] ^ own_r) == 7'h04 // RQ4
    |=> match_r)
    else $error("masked address bit 2 blocked a match");
  a_mask_bit1: assert property (cmp && ctrl_r[RESTART_BIT] && (ssh_r[7:1] ^ own_r) == 7'h02 // RQ6
    |=> match_r)
    else $error("masked address bit 1 blocked a match");
  a_mask_nomatch: assert property (cmp && !match_r && ((ssh_r[7:1] ^ own_r) & ~mask7) != 7'h00 // RQ7
    && !(wr_pend_r && baddr_r == STATUS_OFS) |=> !match_r)
    else $error("unmasked address difference still matched");
  a_mask_kept: assert property (slave_on && !(wr_pend_r && baddr_r == CTRL_OFS) // RQ2
    |=> ctrl_r[3:1] == $past(ctrl_r[3:1]))
    else $error("slave mask enables changed without a write");
endmodule

// [icam_pkg.sv]
// Purpose: Constants and types for the serial-port command and address-mask block
// Assumes: 32-bit AHB-Lite register access, 50 MHz mclk_i
// Notes: Bits 3..1 of the control register mean one thing in master mode and another in slave mode
// What this block does
// RQ1 - Receive request starts master byte reception
// RQ2 - Slave mode: bit 3 masks address bit 3
// RQ3 - Stop request sends Stop, then self-clears
// RQ4 - Slave mode: bit 2 masks address bit 2
// RQ5 - Restart request sends Repeated Start, self-clears
// RQ6 - Slave mode: bit 1 masks address bit 1
// RQ7 - Masked address bits are ignored in compare
package icam_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OWN_ADDR_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] NO_REG = 8'hff;
  localparam int MODE_BIT = 0;
  localparam int RESTART_BIT = 1;
  localparam int STOP_BIT = 2;
  localparam int RECV_BIT = 3;
  localparam int ENABLE_BIT = 7;
  localparam int ST_MATCH_BIT = 0;
  localparam int ST_RXV_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;
  localparam logic [7:0] RXD_RST = 8'h00;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_QTR_NS = 2500;
  localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RX_BITS = 4'h8;
  localparam logic [3:0] ADDR_FRAME_BITS = 4'h8;

  typedef enum logic [3:0] {
    ICAM_IDLE = 4'h0,
    ICAM_RS_SDA = 4'h1,
    ICAM_RS_SCL = 4'h2,
    ICAM_RS_START = 4'h3,
    ICAM_RS_HOLD = 4'h4,
    ICAM_P_SDA = 4'h5,
    ICAM_P_SCL = 4'h6,
    ICAM_P_REL = 4'h7,
    ICAM_RX_LOW = 4'h8,
    ICAM_RX_HIGH = 4'h9
  } icam_state_t;
endpackage

// [icam_bus_dev.sv]
// Purpose: Neighbour device on the two-wire bus, seen from the block's pins
// Assumes: Lines are wired-AND with pull-ups, released pull means high
// Notes: Acts as transmitter for master receive and as bus master for slave tests
`timescale 1ns/10ps
module icam_bus_dev
(
  input wire logic scl_i,
  input wire logic serve_i,
  input wire logic [7:0] tx_byte_i,
  output logic scl_pull_o,
  output logic sda_pull_o
);
  int bit_cnt = 0;

  initial
  begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end

  // Next bit goes out while SCL is low, MSB first
  always @(negedge scl_i)
  begin
    if (serve_i && bit_cnt < 8)
    begin
      sda_pull_o = !tx_byte_i[7 - bit_cnt];
      bit_cnt = bit_cnt + 1;
    end
  end

  // Hold time over: let the pull-up take SDA back
  always @(posedge scl_i)
  begin
    if (bit_cnt == 8)
    begin
      #90;
      sda_pull_o = 1'b0;
    end
  end

  always @(negedge serve_i)
  begin
    bit_cnt = 0;
  end

  // Start, eight bits at 160 ns per bit, no acknowledge, then Stop
  task automatic send_frame(input logic [7:0] b);
    #7;
    sda_pull_o = 1'b1;
    #80;
    for (int i = 7; i >= 0; i--)
    begin
      scl_pull_o = 1'b1;
      #40;
      sda_pull_o = !b[i];
      #40;
      scl_pull_o = 1'b0;
      #80;
    end
    scl_pull_o = 1'b1;
    #40;
    sda_pull_o = 1'b1;
    #40;
    scl_pull_o = 1'b0;
    #80;
    sda_pull_o = 1'b0;
    #80;
  endtask
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench for the command and address-mask block
// Assumes: Single AHB-Lite master, QTR_CYC shortened to 4
// Notes: Bus lines resolved here from every party's pull enables
`timescale 1ns/10ps
module tb_top;
  import icam_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, dev_scl, dev_sda;
  logic serve = 1'b0;
  logic [31:0] mismatches = 0;
  logic [31:0] num_checks = 0;
  logic [31:0] starts = 0;
  logic [31:0] stops = 0;
  logic [31:0] rd, s0;
  int cycles = 0;
  wire scl_w = !(scl_oe | dev_scl);
  wire sda_w = !(sda_oe | dev_sda);
  logic [7:0] msk_tab [6] = '{8'h00, 8'h00, 8'h02, 8'h04, 8'h08, 8'h04};
  logic [6:0] adr_tab [6] = '{7'h2a, 7'h28, 7'h28, 7'h2e, 7'h22, 7'h28};
  logic [31:0] hit_tab [6] = '{1, 0, 1, 1, 1, 0};

  icam_top #(.QTR_CYC(4)) u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe));
  icam_bus_dev u_dev (.scl_i(scl_w), .serve_i(serve), .tx_byte_i(8'ha5),
    .scl_pull_o(dev_scl), .sda_pull_o(dev_sda));

  initial
  begin
    forever #10 mclk_i = ~mclk_i;
  end

  always @(negedge sda_w) if (scl_w === 1'b1) starts = starts + 1;
  always @(posedge sda_w) if (scl_w === 1'b1) stops = stops + 1;

  task automatic tally_and_finish;
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, far beyond the whole sequence
  always @(posedge mclk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Address phase held until hready, then data phase until hready
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk_i); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk_i); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] w);
    for (int i = 0; i < 300; i++)
    begin
      ahb(1'b0, a, 32'h0, rd);
      if ((rd & m) === w) break;
    end
  endtask

  task automatic test_regs;
    ahb(1'b0, 32'h0, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'b1, 32'h100, 32'hffffffff, rd);
    ahb(1'b0, 32'h100, 32'h0, rd);
    check(rd, 32'h0);
    check({31'h0, hresp}, 32'h0);
    check({30'h0, scl_o, sda_o}, 32'h0);
  endtask

  task automatic test_master;
    ahb(1'b1, 32'h0, 32'h81, rd);
    repeat (40) @(posedge mclk_i);
    ahb(1'b0, 32'h8, 32'h0, rd);
    check(rd & 32'h4, 32'h0);
    s0 = starts;
    ahb(1'b1, 32'h0, 32'h83, rd);
    poll(32'h0, 32'h2, 32'h0);
    check(rd, 32'h81);
    check(starts - s0, 32'h1);
    s0 = stops;
    ahb(1'b1, 32'h0, 32'h85, rd);
    poll(32'h0, 32'h4, 32'h0);
    check(rd, 32'h81);
    check(stops - s0, 32'h1);
    serve <= 1'b1;
    ahb(1'b1, 32'h0, 32'h89, rd);
    poll(32'h8, 32'h2, 32'h2);
    check(rd & 32'hff02, 32'ha502);
    ahb(1'b0, 32'h0, 32'h0, rd);
    check(rd, 32'h81);
    serve <= 1'b0;
  endtask

  // Own address 0x2a; entry 0 sends it unchanged, every other entry flips one address bit
  task automatic test_slave;
    ahb(1'b1, 32'h4, 32'h2a, rd);
    ahb(1'b0, 32'h4, 32'h0, rd);
    check(rd, 32'h2a);
    for (int i = 0; i < 6; i++)
    begin
      ahb(1'b1, 32'h0, 32'h80 | msk_tab[i], rd);
      ahb(1'b1, 32'h8, 32'h3, rd);
      u_dev.send_frame({adr_tab[i], 1'b0});
      @(posedge mclk_i);
      ahb(1'b0, 32'h8, 32'h0, rd);
      check(rd & 32'h1, hit_tab[i]);
    end
  endtask

  initial
  begin
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    test_regs();
    test_master();
    test_slave();
    tally_and_finish();
  end
endmodule
